// file: hdl/sfc_pkg.sv
// Shared constants and types for the serial port format control block
// Assumes one 20 MHz system clock and AXI4-Lite register access
package sfc_pkg;
  // Clock and baud divisor width
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned CLK_HZ        = 1_000_000_000 / CLK_PERIOD_NS;
  localparam int          DIV_W         = 18;

  // Format word field positions
  localparam int          FMT_DATA8     = 0;
  localparam int          FMT_PAR_LO    = 1;
  localparam int          FMT_STOP2     = 3;
  localparam int          FMT_BAUD_LO   = 4;
  localparam logic [15:0] FMT_DEFAULT   = 16'h0086;
  localparam logic [15:0] FMT_P2P_MASK  = 16'h00ff;
  localparam logic [1:0]  PAR_ILLEGAL   = 2'b10;
  localparam logic [3:0]  BAUD_NONE     = 4'h0;
  localparam logic [3:0]  BAUD_P2P_MAX  = 4'hc;

  // Baud rates by format code; code zero has no rate
  localparam int unsigned BAUD_RATE [16] = '{0, 110, 150, 300, 600, 1200, 2400, 4800,
    9600, 19200, 38400, 57600, 115200, 500000, 31250, 921000};

  // Register byte offsets
  localparam int          ADDR_W        = 6;
  localparam logic [5:0]  OFS_FMT1      = 6'h00;
  localparam logic [5:0]  OFS_FMT2      = 6'h04;
  localparam logic [5:0]  OFS_FMT3      = 6'h08;
  localparam logic [5:0]  OFS_CTRL      = 6'h0c;
  localparam logic [5:0]  OFS_ERR       = 6'h10;
  localparam logic [5:0]  OFS_CFG1      = 6'h14;
  localparam logic [5:0]  OFS_CFG2      = 6'h18;
  localparam logic [5:0]  OFS_CFG3      = 6'h1c;

  // Control and error register fields
  localparam int          CTRL_LATCH_LO = 0;
  localparam int          CTRL_RTU_LO   = 4;
  localparam int          CTRL_MSTR_LO  = 8;
  localparam int          ERR_FLAG_BIT  = 0;
  localparam int          ERR_RUN_BIT   = 1;
  localparam int          ERR_CODE_LO   = 8;
  localparam logic [1:0]  RESP_OKAY     = 2'b00;
  localparam logic [1:0]  RESP_SLVERR   = 2'b10;

  // Error codes reported to software
  localparam logic [7:0]  CODE_FUNC     = 8'h01;
  localparam logic [7:0]  CODE_ADDR     = 8'h02;
  localparam logic [7:0]  CODE_RANGE    = 8'h03;
  localparam logic [7:0]  CODE_SUM      = 8'h07;

  typedef enum logic [1:0] {
    ERR_BAD_FUNC  = 2'b00,
    ERR_BAD_ADDR  = 2'b01,
    ERR_BAD_RANGE = 2'b10,
    ERR_BAD_SUM   = 2'b11
  } sfc_err_kind_t;

  typedef enum logic [1:0] {
    MODE_STOP  = 2'b00,
    MODE_FIRST = 2'b01,
    MODE_RUN   = 2'b10
  } sfc_mode_t;

  // Illegal request report from a protocol engine
  typedef struct packed {
    logic          valid;
    sfc_err_kind_t kind;
  } sfc_err_t;

  // Active configuration of one port
  typedef struct packed {
    logic             master;
    logic             rtu;
    logic [3:0]       baud_code;
    logic             stop2;
    logic [1:0]       parity;
    logic             data8;
    logic [DIV_W-1:0] baud_div;
  } sfc_cfg_t;

  localparam sfc_cfg_t CFG_DEFAULT = '{master: 1'b0, rtu: 1'b0, baud_code: 4'h8, stop2: 1'b0,
    parity: 2'b11, data8: 1'b0, baud_div: DIV_W'(CLK_HZ / 9600)};
endpackage

// file: hdl/sfc_port_cfg.sv
// One serial port's format decoder and active configuration
// Assumes apply is a one-cycle pulse on the first scan after stop-to-run
`timescale 1ns/1ns
`default_nettype none
module sfc_port_cfg #(
  parameter bit MULTIDROP = 1'b0
) (
  // Clock and reset
  input  wire logic            aclk,
  input  wire logic            aresetn,
  // Settings from registers
  input  wire logic            apply,
  input  wire logic [15:0]     fmt_word,
  input  wire logic            rtu_sel,
  input  wire logic            master_sel,
  // Active configuration
  output sfc_pkg::sfc_cfg_t    cfg,
  output logic                 reject
);
  logic [sfc_pkg::DIV_W-1:0] div_tab [16];
  logic [15:0]               word;
  logic                      legal;
  sfc_pkg::sfc_cfg_t         cfg_ff;
  sfc_pkg::sfc_cfg_t         nxt_cfg;
  logic                      reject_ff;
  logic                      nxt_reject;

  if (sfc_pkg::CLK_HZ / sfc_pkg::BAUD_RATE[15] < 16) begin : g_chk
    $error("clock too slow for the fastest baud rate");
  end

  // Divisor table, one entry per baud code
  for (genvar i = 0; i < 16; i++) begin : g_div
    if (i == 0) begin : g_none
      assign div_tab[i] = '0;
    end else begin : g_rate
      assign div_tab[i] = sfc_pkg::DIV_W'(sfc_pkg::CLK_HZ / sfc_pkg::BAUD_RATE[i]); // [R6]
    end
  end

  // Upper byte is dead on the point-to-point port
  assign word = MULTIDROP ? fmt_word : (fmt_word & sfc_pkg::FMT_P2P_MASK); // [R10]

  // Reject unknown parity, no rate, or multidrop-only rates on point-to-point
  assign legal = (word[sfc_pkg::FMT_PAR_LO +: 2] != sfc_pkg::PAR_ILLEGAL)
              && (word[sfc_pkg::FMT_BAUD_LO +: 4] != sfc_pkg::BAUD_NONE)
              && (MULTIDROP || word[sfc_pkg::FMT_BAUD_LO +: 4] <= sfc_pkg::BAUD_P2P_MAX); // [R7] [R8]

  // Next configuration
  always_comb begin
    nxt_cfg            = cfg_ff;
    nxt_reject         = reject_ff;
    nxt_cfg.rtu        = rtu_sel;    // [R12]
    nxt_cfg.master     = master_sel; // [R13]
    if (apply) begin                 // [R11]
      nxt_reject = !legal;
      if (legal) begin
        nxt_cfg.data8     = word[sfc_pkg::FMT_DATA8];                  // [R3]
        nxt_cfg.parity    = word[sfc_pkg::FMT_PAR_LO +: 2];            // [R5]
        nxt_cfg.stop2     = word[sfc_pkg::FMT_STOP2];                  // [R5]
        nxt_cfg.baud_code = word[sfc_pkg::FMT_BAUD_LO +: 4];           // [R6]
        nxt_cfg.baud_div  = div_tab[word[sfc_pkg::FMT_BAUD_LO +: 4]];  // [R6]
      end
    end
  end

  // Registers; reset restores the default format
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_ff    <= sfc_pkg::CFG_DEFAULT; // [R15]
      reject_ff <= 1'b0;
    end else begin
      cfg_ff    <= nxt_cfg;
      reject_ff <= nxt_reject;
    end
  end

  assign cfg    = cfg_ff;
  assign reject = reject_ff;
endmodule
`default_nettype wire

// file: hdl/sfc_top.sv
// Format control and error reporting for three serial ports, AXI4-Lite slave
// Assumes run_mode is an asynchronous level from the run/stop logic
// What this block does
// [R1] Illegal host request sets the error flag and stores its code.
// [R2] Codes: 01 bad function, 02 bad address, 03 out of range, 07 checksum.
// [R3] Format bit 0 picks 7 data bits when clear, 8 when set.
// [R4] Software must pick 8 data bits whenever RTU framing is used.
// [R5] Bits 1-2 pick parity none, odd or even; bit 3 picks stop bits.
// [R6] Bits 4-7 pick baud; codes D, E, F exist on multidrop ports only.
// [R7] Point-to-point port runs at most 115200 baud, master or slave, ASCII or RTU.
// [R8] Multidrop ports run up to 921 kbit/s.
// [R9] All three ports work at once and independently.
// [R10] Point-to-point format bits 8 to 15 are ignored.
// [R11] First scan after stop-to-run reconfigures each latched port from its word.
// [R12] Per-port framing flag: set for RTU, clear for ASCII.
// [R13] Each port can be bus master or slave.
// [R14] A changed format survives the move from run to stop.
// [R15] After reset every port returns to 9600 baud, 7 bits, even, 1 stop.
//
// The register offsets and the AXI4-Lite slave port were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module sfc_top #(
  parameter int ADDR_W = sfc_pkg::ADDR_W
) (
  // Clock and reset
  input  wire logic               aclk,
  input  wire logic               aresetn,
  // AXI4-Lite write address and data
  input  wire logic [ADDR_W-1:0]  awaddr,
  input  wire logic               awvalid,
  output logic                    awready,
  input  wire logic [31:0]        wdata,
  input  wire logic [3:0]         wstrb,
  input  wire logic               wvalid,
  output logic                    wready,
  // AXI4-Lite write response
  output logic [1:0]              bresp,
  output logic                    bvalid,
  input  wire logic               bready,
  // AXI4-Lite read
  input  wire logic [ADDR_W-1:0]  araddr,
  input  wire logic               arvalid,
  output logic                    arready,
  output logic [31:0]             rdata,
  output logic [1:0]              rresp,
  output logic                    rvalid,
  input  wire logic               rready,
  // Run/stop level and request errors
  input  wire logic               run_mode,
  input  wire sfc_pkg::sfc_err_t  req_err,
  // Active port configurations and error status
  output sfc_pkg::sfc_cfg_t       point_to_point_port_cfg,
  output sfc_pkg::sfc_cfg_t       multidrop_port_a_cfg,
  output sfc_pkg::sfc_cfg_t       multidrop_port_b_cfg,
  output logic                    comm_error_flag,
  output logic [7:0]              comm_error_code
);
  if (ADDR_W < sfc_pkg::ADDR_W) begin : g_chk
    $error("address too narrow for the register map");
  end

  // Register index decode: 0..7 hit, 8 means unmapped
  function automatic logic [3:0] reg_index(input logic [ADDR_W-1:0] a);
    logic [3:0] idx;
    idx = 4'h8;
    // Address bits above the map must be zero; a shift stays legal when
    // the bus is exactly as wide as the map
    if ((a >> sfc_pkg::ADDR_W) == '0) begin
      case (a[sfc_pkg::ADDR_W-1:0])
        sfc_pkg::OFS_FMT1: idx = 4'h0;
        sfc_pkg::OFS_FMT2: idx = 4'h1;
        sfc_pkg::OFS_FMT3: idx = 4'h2;
        sfc_pkg::OFS_CTRL: idx = 4'h3;
        sfc_pkg::OFS_ERR:  idx = 4'h4;
        sfc_pkg::OFS_CFG1: idx = 4'h5;
        sfc_pkg::OFS_CFG2: idx = 4'h6;
        sfc_pkg::OFS_CFG3: idx = 4'h7;
        default:           idx = 4'h8;
      endcase
    end
    return idx;
  endfunction

  // Byte-lane merge for a 16-bit register
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] s);
    logic [15:0] r;
    r = old;
    if (s[0]) r[7:0]  = d[7:0];
    if (s[1]) r[15:8] = d[15:8];
    return r;
  endfunction

  // Map an error kind to its reported code
  function automatic logic [7:0] err_code(input sfc_pkg::sfc_err_kind_t k);
    logic [7:0] c;
    case (k)
      sfc_pkg::ERR_BAD_FUNC:  c = sfc_pkg::CODE_FUNC;
      sfc_pkg::ERR_BAD_ADDR:  c = sfc_pkg::CODE_ADDR;
      sfc_pkg::ERR_BAD_RANGE: c = sfc_pkg::CODE_RANGE;
      default:                c = sfc_pkg::CODE_SUM;
    endcase
    return c;
  endfunction

  // Pack one port's configuration for readback
  function automatic logic [31:0] cfg_word(input sfc_pkg::sfc_cfg_t c, input logic rej);
    return {21'h00_0000, rej, c.master, c.rtu, c.baud_code, c.stop2, c.parity, c.data8};
  endfunction

  logic [15:0]          fmt_ff [3];
  logic [15:0]          nxt_fmt [3];
  logic [11:0]          ctrl_ff;
  logic [11:0]          nxt_ctrl;
  logic                 flag_ff;
  logic                 nxt_flag;
  logic [7:0]           code_ff;
  logic [7:0]           nxt_code;
  logic                 bvalid_ff;
  logic                 nxt_bvalid;
  logic [1:0]           bresp_ff;
  logic [1:0]           nxt_bresp;
  logic                 rvalid_ff;
  logic                 nxt_rvalid;
  logic [31:0]          rdata_ff;
  logic [31:0]          nxt_rdata;
  logic [1:0]           rresp_ff;
  logic [1:0]           nxt_rresp;
  logic                 run_s1_ff;
  logic                 run_s2_ff;
  sfc_pkg::sfc_mode_t   mode_ff;
  sfc_pkg::sfc_mode_t   nxt_mode;
  logic                 wr_go;
  logic                 rd_go;
  logic [3:0]           wr_idx;
  logic [3:0]           rd_idx;
  logic                 first_scan;
  sfc_pkg::sfc_cfg_t    cfg [3];
  logic [2:0]           reject;

  // Bus handshakes; a write takes address and data together
  // Nothing is taken while the previous answer still stands, so at most
  // one write and one read are under way
  assign wr_go   = awvalid && wvalid && !bvalid_ff;
  assign rd_go   = arvalid && !rvalid_ff;
  assign awready = wr_go;
  assign wready  = wr_go;
  assign arready = rd_go;
  assign wr_idx  = reg_index(awaddr);
  assign rd_idx  = reg_index(araddr);

  // Register writes and the error flag
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      nxt_fmt[i] = fmt_ff[i];
    end
    nxt_ctrl   = ctrl_ff;
    nxt_flag   = flag_ff;
    nxt_code   = code_ff;
    nxt_bvalid = bvalid_ff && !bready;
    nxt_bresp  = bresp_ff;
    if (wr_go) begin
      nxt_bvalid = 1'b1;
      nxt_bresp  = (wr_idx == 4'h8) ? sfc_pkg::RESP_SLVERR : sfc_pkg::RESP_OKAY;
      case (wr_idx)
        4'h0, 4'h1, 4'h2: nxt_fmt[wr_idx[1:0]] = merge16(fmt_ff[wr_idx[1:0]], wdata, wstrb);
        4'h3: nxt_ctrl = 12'(merge16({4'h0, ctrl_ff}, wdata, wstrb));
        4'h4: if (wstrb[0] && wdata[sfc_pkg::ERR_FLAG_BIT]) nxt_flag = 1'b0; // Write one to clear
        default: ;
      endcase
    end
    // A new error beats a clear in the same cycle
    if (req_err.valid) begin
      nxt_flag = 1'b1;                  // [R1]
      nxt_code = err_code(req_err.kind); // [R1] [R2]
    end
  end

  // Read data path
  // Configuration readback comes straight from the port decoders
  always_comb begin
    nxt_rvalid = rvalid_ff && !rready;
    nxt_rdata  = rdata_ff;
    nxt_rresp  = rresp_ff;
    if (rd_go) begin
      nxt_rvalid = 1'b1;
      nxt_rresp  = sfc_pkg::RESP_OKAY;
      case (rd_idx)
        4'h0, 4'h1, 4'h2: nxt_rdata = {16'h0000, fmt_ff[rd_idx[1:0]]};
        4'h3: nxt_rdata = {20'h0_0000, ctrl_ff};
        4'h4: begin
          nxt_rdata = '0;
          nxt_rdata[sfc_pkg::ERR_FLAG_BIT]     = flag_ff;
          nxt_rdata[sfc_pkg::ERR_RUN_BIT]      = (mode_ff != sfc_pkg::MODE_STOP);
          nxt_rdata[sfc_pkg::ERR_CODE_LO +: 8] = code_ff;
        end
        4'h5, 4'h6, 4'h7: nxt_rdata = cfg_word(cfg[rd_idx[1:0] - 2'd1], reject[rd_idx[1:0] - 2'd1]);
        default: begin
          nxt_rdata = '0;
          nxt_rresp = sfc_pkg::RESP_SLVERR;
        end
      endcase
    end
  end

  // Run/stop sequence; only the first run cycle applies formats
  // FIRST lasts one cycle, so a run level that stays high never reapplies
  // formats, and dropping to stop leaves the active settings alone
  always_comb begin
    case (mode_ff)
      sfc_pkg::MODE_STOP:  nxt_mode = run_s2_ff ? sfc_pkg::MODE_FIRST : sfc_pkg::MODE_STOP;
      sfc_pkg::MODE_FIRST: nxt_mode = run_s2_ff ? sfc_pkg::MODE_RUN : sfc_pkg::MODE_STOP;
      sfc_pkg::MODE_RUN:   nxt_mode = run_s2_ff ? sfc_pkg::MODE_RUN : sfc_pkg::MODE_STOP; // [R14]
      default:             nxt_mode = sfc_pkg::MODE_STOP;
    endcase
  end
  assign first_scan = (mode_ff == sfc_pkg::MODE_FIRST); // [R11]

  // Register file: format words and control; reset restores default formats
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < 3; i++) begin
        fmt_ff[i] <= sfc_pkg::FMT_DEFAULT; // [R15]
      end
      ctrl_ff <= '0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        fmt_ff[i] <= nxt_fmt[i];
      end
      ctrl_ff <= nxt_ctrl;
    end
  end

  // Error status; the flag holds until software clears it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flag_ff <= 1'b0;
      code_ff <= '0;
    end else begin
      flag_ff <= nxt_flag;
      code_ff <= nxt_code;
    end
  end

  // Bus answers; each stands until its ready edge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_ff <= 1'b0;
      bresp_ff  <= sfc_pkg::RESP_OKAY;
      rvalid_ff <= 1'b0;
      rdata_ff  <= '0;
      rresp_ff  <= sfc_pkg::RESP_OKAY;
    end else begin
      bvalid_ff <= nxt_bvalid;
      bresp_ff  <= nxt_bresp;
      rvalid_ff <= nxt_rvalid;
      rdata_ff  <= nxt_rdata;
      rresp_ff  <= nxt_rresp;
    end
  end

  // Run level synchroniser and run/stop sequence; the pin is asynchronous
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      run_s1_ff <= 1'b0;
      run_s2_ff <= 1'b0;
      mode_ff   <= sfc_pkg::MODE_STOP;
    end else begin
      run_s1_ff <= run_mode;
      run_s2_ff <= run_s1_ff;
      mode_ff   <= nxt_mode;
    end
  end

  // Three independent port decoders; port 0 is point-to-point
  // Framing and master selects act at once; format fields change only
  // when the apply pulse finds a legal word
  for (genvar p = 0; p < 3; p++) begin : g_port // [R9]
    sfc_port_cfg #(
      .MULTIDROP (p != 0)
    ) u_port (
      .aclk       (aclk),
      .aresetn    (aresetn),
      .apply      (first_scan && ctrl_ff[sfc_pkg::CTRL_LATCH_LO + p]), // [R11]
      .fmt_word   (fmt_ff[p]),
      .rtu_sel    (ctrl_ff[sfc_pkg::CTRL_RTU_LO + p]),  // [R12]
      .master_sel (ctrl_ff[sfc_pkg::CTRL_MSTR_LO + p]), // [R13]
      .cfg        (cfg[p]),
      .reject     (reject[p])
    );
  end

  // Outputs
  // Every data output comes straight from a flip-flop
  assign bvalid                  = bvalid_ff;
  assign bresp                   = bresp_ff;
  assign rvalid                  = rvalid_ff;
  assign rdata                   = rdata_ff;
  assign rresp                   = rresp_ff;
  assign comm_error_flag         = flag_ff;
  assign comm_error_code         = code_ff;
  assign point_to_point_port_cfg = cfg[0];
  assign multidrop_port_a_cfg    = cfg[1];
  assign multidrop_port_b_cfg    = cfg[2];
endmodule
`default_nettype wire

// file: testbench/sfc_top_assertions.sv
// Checker for the serial port format control block
// Assumes it is bound into sfc_top and sees only its ports
`timescale 1ns/1ns
`default_nettype none
module sfc_top_assertions (
  // Clock and reset
  input wire logic              aclk,
  input wire logic              aresetn,
  // Bus handshakes
  input wire logic              awvalid,
  input wire logic              awready,
  input wire logic              bvalid,
  input wire logic              bready,
  input wire logic              arvalid,
  input wire logic              arready,
  input wire logic              rvalid,
  input wire logic              rready,
  // Errors and port settings
  input wire sfc_pkg::sfc_err_t req_err,
  input wire sfc_pkg::sfc_cfg_t point_to_point_port_cfg,
  input wire sfc_pkg::sfc_cfg_t multidrop_port_a_cfg,
  input wire sfc_pkg::sfc_cfg_t multidrop_port_b_cfg,
  input wire logic              comm_error_flag,
  input wire logic [7:0]        comm_error_code
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Error flag and code follow a request report
  a_err_flag_set: assert property (req_err.valid |=> comm_error_flag)
    else $error("error flag not set");
  a_err_code_low: assert property (req_err.valid && req_err.kind != sfc_pkg::ERR_BAD_SUM |=>
    comm_error_code == 8'($past(req_err.kind)) + 8'h01) else $error("wrong error code");
  a_err_code_sum: assert property (req_err.valid && req_err.kind == sfc_pkg::ERR_BAD_SUM |=>
    comm_error_code == 8'h07) else $error("wrong checksum code");
  // Bus answers one cycle after acceptance and clear on ready
  a_write_answer: assert property (awvalid && awready |=> bvalid) else $error("no write answer");
  a_write_done: assert property (bvalid && bready |=> !bvalid) else $error("write answer stuck");
  a_read_answer: assert property (arvalid && arready |=> rvalid) else $error("no read answer");
  a_read_done: assert property (rvalid && rready |=> !rvalid) else $error("read answer stuck");
  // Active formats stay within legal codes, with the right fast divisor and the default after reset
  a_p2p_baud_cap: assert property (point_to_point_port_cfg.baud_code inside {[4'h1:4'hc]})
    else $error("point-to-point baud out of range");
  a_parity_legal: assert property (point_to_point_port_cfg.parity != 2'b10 &&
    multidrop_port_a_cfg.parity != 2'b10 && multidrop_port_b_cfg.parity != 2'b10)
    else $error("illegal parity active");
  a_md_fast_div: assert property (multidrop_port_a_cfg.baud_code == 4'hf |->
    multidrop_port_a_cfg.baud_div == 18'd21) else $error("fast divisor wrong");
  a_reset_default: assert property (!$past(aresetn) |->
    point_to_point_port_cfg == sfc_pkg::CFG_DEFAULT && multidrop_port_b_cfg == sfc_pkg::CFG_DEFAULT)
    else $error("format not default after reset");
  // Main scenarios reached
  c_err_seen: cover property (req_err.valid);
  c_fast_port: cover property (multidrop_port_a_cfg.baud_code == 4'hf);
  c_rtu_p2p: cover property (point_to_point_port_cfg.rtu);
endmodule
bind sfc_top sfc_top_assertions u_chk (.aclk, .aresetn, .awvalid, .awready, .bvalid, .bready,
  .arvalid, .arready, .rvalid, .rready, .req_err, .point_to_point_port_cfg, .multidrop_port_a_cfg,
  .multidrop_port_b_cfg, .comm_error_flag, .comm_error_code);
`default_nettype wire

// file: testbench/sfc_host_model.sv
// Far-side station model: run/stop level and illegal request reports
// Assumes tasks are called just after a rising clock edge
`timescale 1ns/1ns
`default_nettype none
module sfc_host_model (
  // Clock
  input  wire logic         aclk,
  // Run level and request errors
  output logic              run_mode,
  output sfc_pkg::sfc_err_t req_err
);
  // Idle in stop with no report
  initial begin
    run_mode = 1'b0;
    req_err = '0;
  end
  // Change the run level after the next edge
  task automatic set_run(input logic r);
    @(posedge aclk);
    run_mode <= r;
  endtask
  // Report one illegal request for one cycle
  task automatic bad_req(input sfc_pkg::sfc_err_kind_t k);
    @(posedge aclk);
    req_err <= '{1'b1, k};
    @(posedge aclk);
    req_err <= '0;
  endtask
endmodule
`default_nettype wire

// file: testbench/sfc_top_test.sv
// Self-checking bench for the serial port format control block
// Assumes an AXI4-Lite master here and the station model for run and errors
`timescale 1ns/1ns
`default_nettype none
module sfc_top_test;
  // Bus, run and status signals
  logic              aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic              awready, wready, bvalid, arready, rvalid, run_mode, comm_error_flag;
  logic [5:0]        awaddr, araddr;
  logic [31:0]       wdata, rdata;
  logic [3:0]        wstrb;
  logic [1:0]        bresp, rresp;
  logic [7:0]        comm_error_code;
  sfc_pkg::sfc_err_t req_err;
  sfc_pkg::sfc_cfg_t c1, c2, c3;
  int                fails, checks;
  sfc_top dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .run_mode, .req_err, .point_to_point_port_cfg(c1), .multidrop_port_a_cfg(c2),
    .multidrop_port_b_cfg(c3), .comm_error_flag, .comm_error_code);
  sfc_host_model host (.aclk, .run_mode, .req_err);
  // Clock at 20 MHz
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  // Compare and count
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      fails++;
      $display("mismatch at %0t: saw %h want %h", $time, s, e);
    end
  endtask
  // Verdict and end of run
  task automatic results();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Bounded wait until a handshake output is high at a falling edge
  // Selector: 0 write taken, 1 write answer, 2 read taken, 3 read answer
  task automatic hs(input int w);
    int n;
    n = 0;
    @(negedge aclk);
    while ((w == 0 ? awready : w == 1 ? bvalid : w == 2 ? arready : rvalid) !== 1'b1) begin
      n++;
      if (n > 100) begin
        fails++;
        results();
      end
      @(negedge aclk);
    end
  endtask
  // Register write with response check
  task automatic wc(input logic [5:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'h3;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    hs(0);
    chk(32'(wready), 32'h0000_0001);
    @(posedge aclk);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    hs(1);
    chk(32'(bresp), 32'(er));
    @(posedge aclk);
    bready <= 1'b0;
  endtask
  // Register read with data and response check
  task automatic rc(input logic [5:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    hs(2);
    @(posedge aclk);
    arvalid <= 1'b0;
    hs(3);
    chk(rdata, ed);
    chk(32'(rresp), 32'(er));
    @(posedge aclk);
    rready <= 1'b0;
  endtask
  // Expected active configuration
  function automatic sfc_pkg::sfc_cfg_t mk(input logic m, input logic r, input logic [3:0] b,
    input logic s, input logic [1:0] p, input logic d, input int unsigned rate);
    mk = '{m, r, b, s, p, d, '0};
    mk.baud_div = 18'(sfc_pkg::CLK_HZ / rate);
  endfunction
  // Stop long enough to be seen, then run and let the first scan land
  task automatic go();
    host.set_run(1'b0);
    repeat (4) @(posedge aclk);
    host.set_run(1'b1);
    repeat (8) @(posedge aclk);
    @(negedge aclk);
  endtask
  // Reset values, unmapped places
  task automatic t_reset();
    rc(6'h00, 32'h0000_0086, 2'b00);
    rc(6'h08, 32'h0000_0086, 2'b00);
    rc(6'h18, 32'h0000_0086, 2'b00);
    rc(6'h20, 32'h0000_0000, 2'b10);
    wc(6'h24, 32'h0000_0001, 2'b10);
    chk(32'(c2), 32'(mk(1'b0, 1'b0, 4'h8, 1'b0, 2'b11, 1'b0, 9600)));
    $display("test reset done");
  endtask
  // Latched formats applied on the first scan, others untouched
  task automatic t_apply();
    wc(6'h00, 32'h0000_abc7, 2'b00);
    wc(6'h04, 32'h0000_00f9, 2'b00);
    wc(6'h08, 32'h0000_0083, 2'b00);
    wc(6'h0c, 32'h0000_0215, 2'b00);
    go();
    chk(32'(c1), 32'(mk(1'b0, 1'b1, 4'hc, 1'b0, 2'b11, 1'b1, 115200)));
    chk(32'(c2), 32'(mk(1'b1, 1'b0, 4'h8, 1'b0, 2'b11, 1'b0, 9600)));
    chk(32'(c3), 32'(mk(1'b0, 1'b0, 4'h8, 1'b0, 2'b01, 1'b1, 9600)));
    rc(6'h14, 32'h0000_01c7, 2'b00);
    host.set_run(1'b0);
    repeat (6) @(posedge aclk);
    @(negedge aclk);
    chk(32'(c1), 32'(mk(1'b0, 1'b1, 4'hc, 1'b0, 2'b11, 1'b1, 115200)));
    wc(6'h0c, 32'h0000_0002, 2'b00);
    go();
    chk(32'(c2), 32'(mk(1'b0, 1'b0, 4'hf, 1'b1, 2'b00, 1'b1, 921000)));
    chk(32'(c1), 32'(mk(1'b0, 1'b0, 4'hc, 1'b0, 2'b11, 1'b1, 115200)));
    $display("test apply done");
  endtask
  // Multidrop-only rate and bad parity are not applied
  task automatic t_reject();
    wc(6'h00, 32'h0000_00d1, 2'b00);
    wc(6'h08, 32'h0000_0084, 2'b00);
    wc(6'h0c, 32'h0000_0005, 2'b00);
    go();
    chk(32'(c1), 32'(mk(1'b0, 1'b0, 4'hc, 1'b0, 2'b11, 1'b1, 115200)));
    chk(32'(c3), 32'(mk(1'b0, 1'b0, 4'h8, 1'b0, 2'b01, 1'b1, 9600)));
    rc(6'h14, 32'h0000_04c7, 2'b00);
    $display("test reject done");
  endtask
  // Every error kind sets the flag with its code; clear by writing one
  task automatic t_err();
    logic [7:0] tab [4];
    tab = '{8'h01, 8'h02, 8'h03, 8'h07};
    for (int k = 0; k < 4; k++) begin
      host.bad_req(sfc_pkg::sfc_err_kind_t'(k));
      @(negedge aclk);
      chk(32'(comm_error_flag), 32'h0000_0001);
      chk(32'(comm_error_code), 32'(tab[k]));
    end
    rc(6'h10, 32'h0000_0703, 2'b00);
    wc(6'h10, 32'h0000_0001, 2'b00);
    rc(6'h10, 32'h0000_0702, 2'b00);
    $display("test errors done");
  endtask
  // Reset, then the scenarios
  initial begin
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    awaddr = '0;
    araddr = '0;
    wdata = '0;
    wstrb = '0;
    fails = 0;
    checks = 0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_apply();
    t_reject();
    t_err();
    results();
  end
endmodule
`default_nettype wire
